// ==== shared/cfgwd_pkg.sv ====
// Constants and types shared by the configuration word and watchdog block.
package cfgwd_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam logic [7:0] OFF_CONFIG_WORD0 = 8'h00;
	localparam logic [7:0] OFF_WDT_CONTROL  = 8'h04;
	localparam logic [7:0] OFF_WDT_STATUS   = 8'h08;
	localparam logic [7:0] OFF_IRQ_STATUS   = 8'h0C;
	localparam logic [7:0] OFF_IRQ_MASK     = 8'h10;

	// ****************************************************************
	// Configuration word 0 fields
	// ****************************************************************
	localparam int unsigned CODE_PROT_BIT = 28;
	localparam int unsigned BOOT_WP_BIT   = 24;
	localparam int unsigned PROG_WP_LSB   = 12;
	localparam int unsigned PROG_WP_W     = 8;
	localparam int unsigned DBG_CHAN_BIT  = 3;
	localparam int unsigned DEBUG_LSB     = 0;
	localparam int unsigned DEBUG_W       = 2;
	localparam logic [31:0] CFG0_RESET    = 32'h0000_0000;

	// ****************************************************************
	// Watchdog control, status and interrupt fields
	// ****************************************************************
	localparam int unsigned CTL_ENABLE_BIT = 0;
	localparam int unsigned CTL_CLEAR_BIT  = 1;
	localparam int unsigned CTL_PS_LSB     = 8;
	localparam int unsigned PS_SEL_W       = 5;
	localparam logic [4:0]  PS_SEL_RESET   = 5'h00;
	localparam logic        SW_EN_RESET    = 1'b0;
	localparam int unsigned STS_RUN_BIT    = 0;
	localparam int unsigned STS_CFGEN_BIT  = 1;
	localparam int unsigned STS_COUNT_LSB  = 16;
	localparam int unsigned IRQ_W          = 4;
	localparam int unsigned IRQ_WDT_RESET  = 0;
	localparam int unsigned IRQ_WDT_WAKE   = 1;
	localparam int unsigned IRQ_PROG_DENY  = 2;
	localparam int unsigned IRQ_BOOT_DENY  = 3;
	localparam logic [3:0]  IRQ_RESET      = 4'h0;

	// ****************************************************************
	// Watchdog timing
	// ****************************************************************
	localparam int unsigned WDT_PS_W       = 20;
	localparam logic [5:0]  WDT_PS_W6      = 6'h14;
	localparam logic [4:0]  WDT_PS_MAX_SEL = 5'h14;
	localparam int unsigned WDT_CNT_W      = 16;
	localparam logic [15:0] WDT_PERIOD_TICKS = 16'h03FF;

	typedef enum logic [1:0] {
		CFGWD_PH_LOAD = 2'b01,
		CFGWD_PH_RUN  = 2'b10
	} cfgwd_phase_e;

endpackage

// ==== shared/cfgwd_wdt_if.sv ====
// Interface between the register side and the watchdog counter core.
`timescale 1ns/1ps
interface cfgwd_wdt_if;
	logic        run;
	logic        clear;
	logic        tick;
	logic [4:0]  ps_sel;
	logic [15:0] period;
	logic        timeout;
	logic [15:0] count;

	modport ctrl (output run, output clear, output tick, output ps_sel,
		output period, input timeout, input count);
	modport core (input run, input clear, input tick, input ps_sel,
		input period, output timeout, output count);
endinterface

// ==== hw/cfgwd_wdt_core.sv ====
// Watchdog postscaler and time-out counter, advanced by oscillator ticks.
`timescale 1ns/1ps
module cfgwd_wdt_core
	import cfgwd_pkg::*;
(
	input  wire logic   i_mclk,
	input  wire logic   i_resetn,
	cfgwd_wdt_if.core   wdt
);

	typedef struct packed {
		logic [WDT_PS_W-1:0]  ps_cnt;
		logic [WDT_CNT_W-1:0] cnt;
		logic                 timeout;
	} cfgwd_core_s;

	cfgwd_core_s state;
	cfgwd_core_s next_state;
	logic [4:0]  sel_c;
	logic [5:0]  shift;
	logic [WDT_PS_W-1:0] ps_mask;

	// ****************************************************************
	// Counting
	// ****************************************************************
	always_comb
	begin
		next_state = state;
		next_state.timeout = 1'b0;
		sel_c = (wdt.ps_sel > WDT_PS_MAX_SEL) ? WDT_PS_MAX_SEL : wdt.ps_sel;
		shift = WDT_PS_W6 - {1'b0, sel_c};
		ps_mask = {WDT_PS_W{1'b1}} >> shift;
		if (!wdt.run || wdt.clear)
		begin
			next_state.ps_cnt = '0;
			next_state.cnt = '0;
		end
		else if (wdt.tick)
		begin
			if (state.ps_cnt == ps_mask)
			begin
				next_state.ps_cnt = '0;
				if (state.cnt == wdt.period)
				begin
					next_state.cnt = '0;
					next_state.timeout = 1'b1;
				end
				else
				begin
					next_state.cnt = state.cnt + 16'h0001;
				end
			end
			else
			begin
				next_state.ps_cnt = state.ps_cnt + 20'h00001;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
			state <= '0;
		else
			state <= next_state;
	end

	assign wdt.timeout = state.timeout;
	assign wdt.count   = state.cnt;

endmodule

// ==== hw/cfgwd_top.sv ====
// Configuration word 0 holder, flash access gating and watchdog timer.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module cfgwd_top
	import cfgwd_pkg::*;
#(
	parameter logic [15:0] P_WDT_PERIOD = WDT_PERIOD_TICKS
)
(
	input  wire logic              i_mclk,
	input  wire logic              i_resetn,
	input  wire logic [31:0]       i_cfg_word0,
	input  wire logic              i_cfg_wdt_enable,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [31:0]       i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic      [31:0]       o_rdata,
	input  wire logic              i_low_power_rc_oscillator_tick,
	input  wire logic              i_sleep,
	input  wire logic              i_idle,
	input  wire logic              i_ext_prog_req,
	output logic                   o_ext_prog_grant,
	input  wire logic              i_boot_wr_req,
	output logic                   o_boot_wr_grant,
	output logic      [PROG_WP_W-1:0] o_program_flash_write_protect,
	output logic                   o_debug_channel_select,
	output logic      [DEBUG_W-1:0] o_debug_mode,
	output logic                   o_device_reset,
	output logic                   o_wake,
	output logic                   o_irq
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		cfgwd_phase_e    phase;
		logic [31:0]     cfg0;
		logic            cfg_wdt_en;
		logic            sw_en;
		logic [4:0]      ps_sel;
		logic            clear;
		logic [IRQ_W-1:0] irq_status;
		logic [IRQ_W-1:0] irq_mask;
		logic [31:0]     rdata;
		logic            prog_grant;
		logic            boot_grant;
		logic            dev_reset;
		logic            wake;
	} cfgwd_top_s;

	cfgwd_top_s state;
	cfgwd_top_s next_state;

	logic             wr_ctl;
	logic             wr_irq_status;
	logic             wr_irq_mask;
	logic             code_protect;
	logic             boot_flash_write_protect;
	logic             run;
	logic [IRQ_W-1:0] events;
	logic [IRQ_W-1:0] w1c;
	logic [31:0]      rd_value;

	cfgwd_wdt_if wdt_bus ();

	// ****************************************************************
	// Watchdog core
	// ****************************************************************
	cfgwd_wdt_core u_core (
		.i_mclk   (i_mclk),
		.i_resetn (i_resetn),
		.wdt      (wdt_bus)
	);

	// ****************************************************************
	// Decode and derived levels
	// ****************************************************************
	always_comb
	begin
		wr_ctl        = i_wr && (i_addr == OFF_WDT_CONTROL);
		wr_irq_status = i_wr && (i_addr == OFF_IRQ_STATUS);
		wr_irq_mask   = i_wr && (i_addr == OFF_IRQ_MASK);
	end

	// Until the word is loaded the reset value keeps both protections on.
	assign code_protect             = state.cfg0[CODE_PROT_BIT];
	assign boot_flash_write_protect = state.cfg0[BOOT_WP_BIT];

	// Configuration enable cannot be withdrawn by software.
	assign run = state.cfg_wdt_en || state.sw_en;

	assign wdt_bus.run    = run;
	assign wdt_bus.clear  = state.clear;
	assign wdt_bus.tick   = i_low_power_rc_oscillator_tick;
	assign wdt_bus.ps_sel = state.ps_sel;
	assign wdt_bus.period = P_WDT_PERIOD;

	// ****************************************************************
	// Events for the interrupt status
	// ****************************************************************
	always_comb
	begin
		events = '0;
		events[IRQ_WDT_RESET] = wdt_bus.timeout && !(i_sleep || i_idle);
		events[IRQ_WDT_WAKE]  = wdt_bus.timeout && (i_sleep || i_idle);
		events[IRQ_PROG_DENY] = i_ext_prog_req && !code_protect;
		events[IRQ_BOOT_DENY] = i_boot_wr_req && !boot_flash_write_protect;
		w1c = wr_irq_status ? i_wdata[IRQ_W-1:0] : '0;
	end

	// ****************************************************************
	// Read mux
	// ****************************************************************
	always_comb
	begin
		rd_value = 32'h0000_0000;
		unique case (i_addr)
			OFF_CONFIG_WORD0:
			begin
				rd_value = state.cfg0;
			end
			OFF_WDT_CONTROL:
			begin
				rd_value[CTL_ENABLE_BIT] = state.sw_en;
				rd_value[CTL_PS_LSB +: PS_SEL_W] = state.ps_sel;
			end
			OFF_WDT_STATUS:
			begin
				rd_value[STS_RUN_BIT] = run;
				rd_value[STS_CFGEN_BIT] = state.cfg_wdt_en;
				rd_value[STS_COUNT_LSB +: WDT_CNT_W] = wdt_bus.count;
			end
			OFF_IRQ_STATUS:
			begin
				rd_value[IRQ_W-1:0] = state.irq_status;
			end
			OFF_IRQ_MASK:
			begin
				rd_value[IRQ_W-1:0] = state.irq_mask;
			end
			default:
			begin
				rd_value = 32'h0000_0000;
			end
		endcase
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		next_state = state;
		next_state.clear      = 1'b0;
		next_state.prog_grant = 1'b0;
		next_state.boot_grant = 1'b0;
		next_state.dev_reset  = 1'b0;
		next_state.wake       = 1'b0;
		next_state.rdata      = 32'h0000_0000;

		// Configuration is captured once, right after reset release.
		// The reserved bits are kept as programmed; no check is made.
		unique case (state.phase)
			CFGWD_PH_LOAD:
			begin
				next_state.cfg0       = i_cfg_word0;
				next_state.cfg_wdt_en = i_cfg_wdt_enable;
				next_state.phase      = CFGWD_PH_RUN;
			end
			CFGWD_PH_RUN:
			begin
				next_state.phase = CFGWD_PH_RUN;
			end
			default:
			begin
				next_state.phase = CFGWD_PH_LOAD;
			end
		endcase

		if (i_rd)
		begin
			next_state.rdata = rd_value;
		end

		if (wr_ctl)
		begin
			next_state.sw_en  = i_wdata[CTL_ENABLE_BIT];
			next_state.ps_sel = i_wdata[CTL_PS_LSB +: PS_SEL_W];
			next_state.clear  = i_wdata[CTL_CLEAR_BIT];
		end

		if (wr_irq_mask)
		begin
			next_state.irq_mask = i_wdata[IRQ_W-1:0];
		end

		// A new event in the clearing cycle survives the clear.
		next_state.irq_status = (state.irq_status & ~w1c) | events;

		// Flash access answers are one-cycle grants after each permitted request.
		if (i_ext_prog_req && code_protect)
		begin
			next_state.prog_grant = 1'b1;
		end
		if (i_boot_wr_req && boot_flash_write_protect)
		begin
			next_state.boot_grant = 1'b1;
		end

		if (wdt_bus.timeout)
		begin
			if (i_sleep || i_idle)
			begin
				next_state.wake = 1'b1;
			end
			else
			begin
				next_state.dev_reset = 1'b1;
			end
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			state.phase      <= CFGWD_PH_LOAD;
			state.cfg0       <= CFG0_RESET;
			state.cfg_wdt_en <= 1'b0;
			state.sw_en      <= SW_EN_RESET;
			state.ps_sel     <= PS_SEL_RESET;
			state.clear      <= 1'b0;
			state.irq_status <= IRQ_RESET;
			state.irq_mask   <= IRQ_RESET;
			state.rdata      <= 32'h0000_0000;
			state.prog_grant <= 1'b0;
			state.boot_grant <= 1'b0;
			state.dev_reset  <= 1'b0;
			state.wake       <= 1'b0;
		end
		else
		begin
			state <= next_state;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign o_rdata                       = state.rdata;
	assign o_ext_prog_grant              = state.prog_grant;
	assign o_boot_wr_grant               = state.boot_grant;
	assign o_program_flash_write_protect =
		state.cfg0[PROG_WP_LSB +: PROG_WP_W];
	assign o_debug_channel_select        = state.cfg0[DBG_CHAN_BIT];
	assign o_debug_mode                  = state.cfg0[DEBUG_LSB +: DEBUG_W];
	assign o_device_reset                = state.dev_reset;
	assign o_wake                        = state.wake;
	assign o_irq = |(state.irq_status & state.irq_mask);

endmodule

// ==== tb/cfgwd_chk.sv ====
// Port assertions for the configuration word and watchdog block.
`timescale 1ns/1ps
module cfgwd_chk
	import cfgwd_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_resetn,
	input  wire logic [31:0] i_cfg_word0,
	input  wire logic        i_low_power_rc_oscillator_tick,
	input  wire logic        i_sleep,
	input  wire logic        i_idle,
	input  wire logic        i_ext_prog_req,
	input  wire logic        o_ext_prog_grant,
	input  wire logic        i_boot_wr_req,
	input  wire logic        o_boot_wr_grant,
	input  wire logic        o_device_reset,
	input  wire logic        o_wake
);
	// ****************************************************************
	// Properties
	// ****************************************************************
	logic live;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);
	// A request at the release edge still sees the cleared word.
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
			live <= 1'b0;
		else
			live <= 1'b1;
	end
	sequence s_prog_ok;
		live && i_ext_prog_req && i_cfg_word0[CODE_PROT_BIT];
	endsequence
	sequence s_boot_ok;
		live && i_boot_wr_req && i_cfg_word0[BOOT_WP_BIT];
	endsequence
	sequence s_fire; o_device_reset || o_wake; endsequence
	property p_prog_given; s_prog_ok |=> o_ext_prog_grant; endproperty
	property p_prog_cause; o_ext_prog_grant |->
		$past(i_ext_prog_req && i_cfg_word0[CODE_PROT_BIT]);
	endproperty
	property p_boot_given; s_boot_ok |=> o_boot_wr_grant; endproperty
	property p_boot_cause; o_boot_wr_grant |->
		$past(i_boot_wr_req && i_cfg_word0[BOOT_WP_BIT]); endproperty
	property p_tick_cause; s_fire |->
		$past(i_low_power_rc_oscillator_tick, 2); endproperty
	property p_reset_awake; o_device_reset |->
		$past(!i_sleep && !i_idle); endproperty
	property p_wake_asleep; o_wake |-> $past(i_sleep || i_idle); endproperty
	property p_fire_once; s_fire |=> !o_device_reset && !o_wake; endproperty
	a_prog_given: assert property (p_prog_given)
		else $error("Programmer grant missing.");
	a_prog_cause: assert property (p_prog_cause)
		else $error("Programmer grant without cause.");
	a_boot_given: assert property (p_boot_given)
		else $error("Boot write grant missing.");
	a_boot_cause: assert property (p_boot_cause)
		else $error("Boot write grant without cause.");
	a_tick_cause: assert property (p_tick_cause)
		else $error("Time-out not caused by an oscillator tick.");
	a_reset_awake: assert property (p_reset_awake)
		else $error("Reset issued while asleep or idle.");
	a_wake_asleep: assert property (p_wake_asleep)
		else $error("Wake issued while awake.");
	a_fire_once: assert property (p_fire_once)
		else $error("Time-out pulse longer than one cycle.");
endmodule
bind cfgwd_top cfgwd_chk u_chk (.i_mclk(i_mclk), .i_resetn(i_resetn),
	.i_cfg_word0(i_cfg_word0),
	.i_low_power_rc_oscillator_tick(i_low_power_rc_oscillator_tick),
	.i_sleep(i_sleep), .i_idle(i_idle), .i_ext_prog_req(i_ext_prog_req),
	.o_ext_prog_grant(o_ext_prog_grant), .i_boot_wr_req(i_boot_wr_req),
	.o_boot_wr_grant(o_boot_wr_grant), .o_device_reset(o_device_reset),
	.o_wake(o_wake));

// ==== tb/tb.sv ====
// Self-checking bench for the configuration word and watchdog block.
`timescale 1ns/1ps
module tb
	import cfgwd_pkg::*;
;
	// ****************************************************************
	// Signals and design
	// ****************************************************************
	logic        i_mclk, i_resetn, i_cfg_wdt_enable, i_wr, i_rd;
	logic        i_low_power_rc_oscillator_tick, i_sleep, i_idle;
	logic        i_ext_prog_req, i_boot_wr_req, o_ext_prog_grant;
	logic        o_boot_wr_grant, o_debug_channel_select;
	logic        o_device_reset, o_wake, o_irq;
	logic [31:0] i_cfg_word0, i_wdata, o_rdata;
	logic [7:0]  i_addr, o_program_flash_write_protect;
	logic [1:0]  o_debug_mode;
	int          n_mismatch, checks_done, n_rst, n_wake;
	// A short period keeps each time-out to a handful of ticks.
	cfgwd_top #(.P_WDT_PERIOD(16'h0003)) dut (.i_mclk, .i_resetn,
		.i_cfg_word0, .i_cfg_wdt_enable, .i_addr, .i_wdata, .i_wr,
		.i_rd, .o_rdata, .i_low_power_rc_oscillator_tick,
		.i_sleep, .i_idle,
		.i_ext_prog_req, .o_ext_prog_grant, .i_boot_wr_req,
		.o_boot_wr_grant, .o_program_flash_write_protect,
		.o_debug_channel_select, .o_debug_mode, .o_device_reset,
		.o_wake, .o_irq);
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] e);
		@(posedge i_mclk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		@(negedge i_mclk);
		cmp("rdata", e, o_rdata);
	endtask
	task automatic req(bit boot, logic e);
		@(posedge i_mclk);
		if (boot)
			i_boot_wr_req <= 1'b1;
		else
			i_ext_prog_req <= 1'b1;
		@(posedge i_mclk);
		i_boot_wr_req <= 1'b0;
		i_ext_prog_req <= 1'b0;
		@(negedge i_mclk);
		cmp("grant", {31'h0, e}, {31'h0,
			boot ? o_boot_wr_grant : o_ext_prog_grant});
	endtask
	// Clear is registered, so ticks are held off until it has landed.
	task automatic wdt(logic [31:0] ctl);
		wr(OFF_WDT_CONTROL, ctl);
		repeat (3) @(posedge i_mclk);
	endtask
	task automatic tick(int n);
		repeat (n)
		begin
			@(posedge i_mclk);
			i_low_power_rc_oscillator_tick <= 1'b1;
			@(posedge i_mclk);
			i_low_power_rc_oscillator_tick <= 1'b0;
		end
		repeat (4) @(posedge i_mclk);
	endtask
	task automatic cnt(int r, int w);
		cmp("resets", 32'(r), 32'(n_rst));
		cmp("wakes", 32'(w), 32'(n_wake));
	endtask
	task automatic rst(logic [31:0] cfg, logic en);
		i_resetn <= 1'b0;
		i_cfg_word0 <= cfg;
		i_cfg_wdt_enable <= en;
		repeat (5) @(posedge i_mclk);
		i_resetn <= 1'b1;
		repeat (2) @(posedge i_mclk);
	endtask
	task automatic summarize();
		$display("Checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ****************************************************************
	// Clock, monitors and tests
	// ****************************************************************
	initial
	begin
		i_mclk = 1'b0;
		forever #4 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk)
	begin
		n_rst += int'(o_device_reset === 1'b1);
		n_wake += int'(o_wake === 1'b1);
	end
	// The whole run needs well under ten thousand cycles.
	initial
	begin
		#100000;
		n_mismatch++;
		summarize();
	end
	initial
	begin
		{i_wr, i_rd, i_sleep, i_idle} = '0;
		i_low_power_rc_oscillator_tick = 1'b0;
		{i_ext_prog_req, i_boot_wr_req, i_cfg_wdt_enable} = '0;
		{i_addr, i_wdata, i_cfg_word0} = '0;
		rst(32'h7EFA5FFE, 1'b0);
		rd(OFF_CONFIG_WORD0, 32'h7EFA5FFE);
		cmp("fields", 32'h52E, {21'h0, o_program_flash_write_protect,
			o_debug_channel_select, o_debug_mode});
		rd(OFF_WDT_STATUS, 32'h0);
		req(1'b0, 1'b1);
		req(1'b1, 1'b0);
		rd(OFF_IRQ_STATUS, 32'h8);
		wr(OFF_IRQ_MASK, 32'hF);
		rd(8'h40, 32'h0);
		cmp("irq", 32'h1, {31'h0, o_irq});
		wr(OFF_IRQ_STATUS, 32'h8);
		rd(OFF_IRQ_STATUS, 32'h0);
		cmp("irq", 32'h0, {31'h0, o_irq});
		wdt(32'h1);
		rd(OFF_WDT_STATUS, 32'h1);
		repeat (40) @(posedge i_mclk);
		cnt(0, 0);
		tick(3);
		cnt(0, 0);
		tick(1);
		cnt(1, 0);
		rd(OFF_IRQ_STATUS, 32'h1);
		tick(2);
		wdt(32'h3);
		tick(3);
		cnt(1, 0);
		tick(1);
		cnt(2, 0);
		wdt(32'h103);
		tick(7);
		cnt(2, 0);
		tick(1);
		cnt(3, 0);
		@(posedge i_mclk);
		i_sleep <= 1'b1;
		wdt(32'h3);
		tick(4);
		cnt(3, 1);
		rd(OFF_IRQ_STATUS, 32'h3);
		@(posedge i_mclk);
		i_sleep <= 1'b0;
		rst(32'h6FF3CFF5, 1'b1);
		rd(OFF_CONFIG_WORD0, 32'h6FF3CFF5);
		cmp("fields", 32'h1E1, {21'h0, o_program_flash_write_protect,
			o_debug_channel_select, o_debug_mode});
		wr(OFF_WDT_CONTROL, 32'h0);
		rd(OFF_WDT_STATUS, 32'h3);
		req(1'b0, 1'b0);
		req(1'b1, 1'b1);
		rd(OFF_IRQ_STATUS, 32'h4);
		cmp("irq", 32'h0, {31'h0, o_irq});
		@(posedge i_mclk);
		i_idle <= 1'b1;
		tick(4);
		cnt(3, 2);
		summarize();
	end
endmodule
